//--- pkg/lpa_regs.svh
// lpa_regs.svh: field positions, widths and cycle counts for the logic/product datapath
// assumes: included by bare name by the package and the datapath module
`ifndef LPA_REGS_SVH
`define LPA_REGS_SVH
`define LPA_SUM_W 32
`define LPA_WORD_W 16
`define LPA_AMODE_BIT 7
`define LPA_DMA_W 7
`define LPA_SAT_POS 32'h7fffffff
`define LPA_SAT_NEG 32'h80000000
`define LPA_PM_NONE 2'h0
`define LPA_PM_L1 2'h1
`define LPA_PM_L4 2'h2
`define LPA_PM_R6 2'h3
`define LPA_CYC_BASE 4'h1
`define LPA_CYC_SARAM_SHARED 4'h3
`define LPA_CYC_EXT_BASE 4'h2
`define LPA_CYC_EXT_CODE_EXTRA 4'h3
`endif

//--- pkg/lpa_pkg.sv
// lpa_pkg: operation codes, memory kinds and the request/answer carriers
// assumes: lpa_regs.svh is on the include path
package lpa_pkg;
	`include "lpa_regs.svh"
	typedef enum logic [1:0] {
		LPA_OP_AND_WITH_BUFFER = 2'b00,
		LPA_OP_ADD_PRODUCT_TO_SUM_REGISTER = 2'b01,
		LPA_OP_APL = 2'b10,
		LPA_OP_NONE = 2'b11
	} lpa_op_t;
	typedef enum logic [1:0] {
		LPA_MEM_DUAL = 2'b00,
		LPA_MEM_SINGLE = 2'b01,
		LPA_MEM_SHARED = 2'b10,
		LPA_MEM_EXT = 2'b11
	} lpa_mem_t;
	// one operation request
	typedef struct packed {
		lpa_op_t op;
		logic [15:0] opcode;
		logic long_imm_given;
		logic [15:0] long_imm;
		logic [15:0] mem_word;
		lpa_mem_t operand_mem;
		logic code_external;
		logic [3:0] wait_d;
		logic [3:0] wait_p;
		logic [7:0] repeat_n;
	} lpa_req_t;
	// memory write-back of the and-into-memory path
	typedef struct packed {
		logic we;
		logic indirect;
		logic [6:0] offset;
		logic [15:0] data;
	} lpa_wb_t;
	typedef enum logic [1:0] {
		LPA_ST_IDLE = 2'b00,
		LPA_ST_BUSY = 2'b01
	} lpa_state_t;
endpackage

//--- rtl/lpa_datapath.sv
// lpa_datapath: and-with-buffer, add-product and and-into-memory execution
// assumes: one request per start pulse, accepted only while idle; operands steady
// assumes: mem_word is the operand the caller has already read; the write-back
// pulse carries the address form so the caller's own address path does the store
// assumes: saturation_enable_in is held steady while an op is busy, since it is
// read only in the final cycle of add_product
//
// Operation
// - and_with_buffer ands main_sum_register with sum_buffer_register into the sum, pc+1, no flags.
// - and_with_buffer and add_product take 1 cycle (1+p external code), n or n+p repeated.
// - add_product shifts product_register by product_shift_mode, always sign extended, and adds.
// - add_product sets carry on carry out of the sum and clears it otherwise.
// - add_product honours saturation_enable and shift mode, ignores sign extension, sets carry and overflow.
// - the shifted-product accumulate path is used by add_product only; no other operation reads it.
// - and_into_memory ands the word with the long immediate, else the mask, writes it back, sum untouched.
// - and_into_memory sets test_control_flag on a zero result, clears it otherwise, touches nothing else.
// - and_into_memory is 1 word and pc+1 without immediate, 2 words and pc+2 with one.
// - opcode bit 7 selects direct 7-bit offset (0) or indirect through aux_pointer register (1).
// - single and_into_memory with mask takes 1, 3 shared single-access, 2+2d external operand.
// - repeated with mask takes n dual, 2n-2 single-access, 4n-2+2nd external operand.

// timing: a start taken at an idle edge loads the cycle count; busy then
// stands for exactly that many cycles, and the cycle after the last one
// shows done together with the new sum, flags, pc advance and write-back.
// the next start may come in the done cycle. register loads and starts
// that arrive while busy are dropped without notice, so a caller must
// watch busy rather than assume that its request was seen.
`timescale 1ns/10ps
`include "lpa_regs.svh"
module lpa_datapath
	import lpa_pkg::*;
#(
	parameter int SUM_W = `LPA_SUM_W
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	input wire lpa_req_t req_in,
	input wire logic product_shift_mode_load_in,
	input wire logic [1:0] product_shift_mode_in,
	input wire logic saturation_enable_in,
	input wire logic sign_extension_mode_in,
	input wire logic [31:0] sum_buffer_load_in,
	input wire logic sum_buffer_we_in,
	input wire logic [31:0] product_load_in,
	input wire logic product_we_in,
	input wire logic [15:0] dynamic_bit_mask_in,
	input wire logic dynamic_bit_mask_we_in,
	input wire logic [31:0] sum_load_in,
	input wire logic sum_we_in,
	output logic busy_out,
	output logic done_out,
	output logic [31:0] main_sum_register_out,
	output logic [31:0] sum_buffer_register_out,
	output logic [31:0] product_register_out,
	output logic [15:0] dynamic_bit_mask_register_out,
	output logic [1:0] product_shift_mode_out,
	output logic carry_flag_out,
	output logic result_saturated_flag_out,
	output logic test_control_flag_out,
	output logic [1:0] pc_advance_out,
	output lpa_wb_t mem_wb_out
);
	// architectural registers
	logic [SUM_W-1:0] sum_reg;
	logic [SUM_W-1:0] sum_next;
	logic [SUM_W-1:0] buf_reg;
	logic [SUM_W-1:0] prod_reg;
	logic [15:0] mask_reg;
	logic [1:0] pm_reg;
	// status flags
	logic carry_reg;
	logic carry_next;
	logic ovf_reg;
	logic ovf_next;
	logic tc_reg;
	logic tc_next;
	// retire pulses
	logic [1:0] pc_adv_reg;
	logic [1:0] pc_adv_next;
	lpa_wb_t wb_reg;
	lpa_wb_t wb_next;
	// sequencer
	lpa_state_t state_reg;
	lpa_req_t hold_reg;
	logic [15:0] cnt_reg;
	logic busy_reg;
	logic done_reg;

	function automatic logic [32:0] shift_product(input logic [31:0] p, input logic [1:0] pm);
		logic [32:0] sx;
		sx = {p[31], p};
		unique case (pm)
			// product as it stands
			`LPA_PM_NONE: begin
				shift_product = sx;
			end
			// one left: fractional products keep their scale
			`LPA_PM_L1: begin
				shift_product = {sx[31:0], 1'b0};
			end
			// four left
			`LPA_PM_L4: begin
				shift_product = {sx[28:0], 4'h0};
			end
			// six right with sign fill, so long sums of products do not wrap
			`LPA_PM_R6: begin
				shift_product = {{6{sx[32]}}, sx[32:6]};
			end
		endcase
	endfunction

	// cycle count for one request; mask-operand table for and_into_memory
	// limitation: the long-immediate form reuses the mask table, so the fetch
	// of its second word is not charged here
	function automatic logic [15:0] op_cycles(input lpa_req_t r);
		logic [15:0] n, d, p, c, nd;
		n = (r.repeat_n == 8'h0) ? 16'h1 : {8'h0, r.repeat_n};
		d = {12'h0, r.wait_d};
		p = r.code_external ? {12'h0, r.wait_p} : 16'h0;
		nd = 16'(n * d);
		c = n;
		if (r.op == LPA_OP_APL) begin
			unique case (r.operand_mem)
				// dual-access operand: one cycle per pass
				LPA_MEM_DUAL: begin
					c = n;
				end
				LPA_MEM_SINGLE: begin
					c = (n == 16'h1) ? 16'(`LPA_CYC_BASE) : 16'((n << 1) - 16'h2);
				end
				// operand and code fight over one single-access block
				LPA_MEM_SHARED: begin
					c = (n == 16'h1) ? 16'(`LPA_CYC_SARAM_SHARED) : 16'((n << 1) + 16'h1);
				end
				LPA_MEM_EXT: begin
					if (n == 16'h1)
						c = 16'(16'(`LPA_CYC_EXT_BASE) + (d << 1));
					else
						c = 16'((n << 2) - 16'h2 + (nd << 1));
				end
			endcase
			// operand and code both outside: the bus turns round more often
			if (r.code_external && r.operand_mem == LPA_MEM_EXT)
				c = 16'(c + 16'(`LPA_CYC_EXT_CODE_EXTRA));
		end
		op_cycles = 16'(c + p);
	endfunction

	// accumulate path of add_product; no other op uses it
	// sign extension ignores sign_extension_mode_in on purpose
	wire [32:0] prod_shifted = shift_product(prod_reg, pm_reg);
	wire [32:0] acc_sum = {1'b0, sum_reg} + {1'b0, prod_shifted[31:0]};
	wire signed_ovf = (sum_reg[31] == prod_shifted[31]) && (acc_sum[31] != sum_reg[31]);
	wire [31:0] sat_value = sum_reg[31] ? `LPA_SAT_NEG : `LPA_SAT_POS;
	wire addr_indirect = hold_reg.opcode[`LPA_AMODE_BIT];
	wire [6:0] addr_offset = hold_reg.opcode[`LPA_DMA_W-1:0];
	wire [15:0] apl_operand = hold_reg.long_imm_given ? hold_reg.long_imm : mask_reg;
	wire [15:0] apl_result = hold_reg.mem_word & apl_operand;
	// handshake: a start is taken only while idle, one during busy is dropped
	wire last_cycle = (state_reg == LPA_ST_BUSY) && (cnt_reg <= 16'h1);
	wire accept = start_in && (state_reg == LPA_ST_IDLE);

	// result selection at the final cycle
	always_comb begin
		sum_next = sum_reg;
		carry_next = carry_reg;
		ovf_next = ovf_reg;
		tc_next = tc_reg;
		pc_adv_next = 2'h0;
		wb_next = '0;
		if (last_cycle) begin
			unique case (hold_reg.op)
				LPA_OP_AND_WITH_BUFFER: begin
					sum_next = sum_reg & buf_reg;
					pc_adv_next = 2'h1;
				end
				LPA_OP_ADD_PRODUCT_TO_SUM_REGISTER: begin
					carry_next = acc_sum[32];
					pc_adv_next = 2'h1;
					if (signed_ovf) begin
						ovf_next = 1'b1;
						sum_next = saturation_enable_in ? sat_value : acc_sum[31:0];
					end else begin
						sum_next = acc_sum[31:0];
					end
				end
				LPA_OP_APL: begin
					tc_next = (apl_result == 16'h0);
					pc_adv_next = hold_reg.long_imm_given ? 2'h2 : 2'h1;
					wb_next.we = 1'b1;
					wb_next.indirect = addr_indirect;
					wb_next.offset = addr_offset;
					wb_next.data = apl_result;
				end
				default: ;
			endcase
		end else if (sum_we_in && state_reg == LPA_ST_IDLE) begin
			// idle load of the sum; refused while busy
			sum_next = sum_load_in;
		end
	end

	// sequencing: count cycles then retire
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= LPA_ST_IDLE;
			hold_reg <= '0;
			cnt_reg <= 16'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= last_cycle;
			if (accept) begin
				state_reg <= LPA_ST_BUSY;
				busy_reg <= 1'b1;
				hold_reg <= req_in;
				cnt_reg <= op_cycles(req_in);
			end else if (last_cycle) begin
				state_reg <= LPA_ST_IDLE;
				busy_reg <= 1'b0;
			end else if (state_reg == LPA_ST_BUSY) begin
				cnt_reg <= cnt_reg - 16'h1;
			end
		end
	end

	// operand registers; loads only while idle so an op sees stable operands
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			buf_reg <= '0;
			prod_reg <= '0;
			mask_reg <= 16'h0;
			pm_reg <= 2'h0;
		end else if (state_reg == LPA_ST_IDLE) begin
			if (sum_buffer_we_in)
				buf_reg <= sum_buffer_load_in;
			if (product_we_in)
				prod_reg <= product_load_in;
			if (dynamic_bit_mask_we_in)
				mask_reg <= dynamic_bit_mask_in;
			if (product_shift_mode_load_in)
				pm_reg <= product_shift_mode_in;
		end
	end

	// main sum and status flags, moved only by a retiring op or an idle load
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sum_reg <= '0;
			carry_reg <= 1'b0;
			ovf_reg <= 1'b0;
			tc_reg <= 1'b0;
		end else begin
			sum_reg <= sum_next;
			carry_reg <= carry_next;
			ovf_reg <= ovf_next;
			tc_reg <= tc_next;
		end
	end

	// retire pulses: pc advance and write-back stand for the done cycle only
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pc_adv_reg <= 2'h0;
			wb_reg <= '0;
		end else begin
			pc_adv_reg <= pc_adv_next;
			wb_reg <= wb_next;
		end
	end

	// outputs straight from flops: handshake
	assign busy_out = busy_reg;
	assign done_out = done_reg;
	// architectural registers
	assign main_sum_register_out = sum_reg;
	assign sum_buffer_register_out = buf_reg;
	assign product_register_out = prod_reg;
	assign dynamic_bit_mask_register_out = mask_reg;
	assign product_shift_mode_out = pm_reg;
	// status flags
	assign carry_flag_out = carry_reg;
	assign result_saturated_flag_out = ovf_reg;
	assign test_control_flag_out = tc_reg;
	// retire pulses
	assign pc_advance_out = pc_adv_reg;
	assign mem_wb_out = wb_reg;
	wire unused_sxm = sign_extension_mode_in;
endmodule

//--- sim/lpa_datapath_chk.sv
// lpa_datapath_chk: port assertions for the logic/product datapath
// assumes: bound to lpa_datapath; one clock, async low reset
`timescale 1ns/10ps
module lpa_datapath_chk
	import lpa_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	input wire lpa_req_t req_in,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic [31:0] main_sum_register_out,
	input wire logic [31:0] sum_buffer_register_out,
	input wire logic [15:0] dynamic_bit_mask_register_out,
	input wire logic carry_flag_out,
	input wire logic result_saturated_flag_out,
	input wire logic test_control_flag_out,
	input wire logic [1:0] pc_advance_out,
	input wire lpa_wb_t mem_wb_out
);
	lpa_req_t rq_reg;
	logic [31:0] sum_reg;
	wire take = start_in && !busy_out;
	wire and_with_buffer_go = take && req_in.op == LPA_OP_AND_WITH_BUFFER && !req_in.code_external
		&& req_in.repeat_n < 8'h2;
	wire apl_done = done_out && rq_reg.op == LPA_OP_APL;
	wire [15:0] mask = rq_reg.long_imm_given ? rq_reg.long_imm : dynamic_bit_mask_register_out;
	// request and sum as taken; loads are ignored while busy, so both hold
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rq_reg <= '0;
			sum_reg <= '0;
		end else if (take) begin
			rq_reg <= req_in;
			sum_reg <= main_sum_register_out;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// short ops: one busy cycle, then a one-cycle done
	a_done_pulse: assert property (done_out |=> !done_out)
		else $error("done too long");
	a_and_with_buffer_cycles: assert property (and_with_buffer_go |=> busy_out ##1 (done_out && !busy_out))
		else $error("and-buffer cycles");
	a_and_with_buffer_result: assert property (and_with_buffer_go |-> ##2 pc_advance_out == 2'h1 &&
		main_sum_register_out == (sum_reg & sum_buffer_register_out)) else $error("and-buffer sum");
	// and-into-memory: write-back, flags, words; sum never touched
	a_apl_sum_kept: assert property (apl_done |-> main_sum_register_out == sum_reg)
		else $error("memory and hit sum");
	a_apl_data: assert property (apl_done |->
		mem_wb_out.we && mem_wb_out.data == (rq_reg.mem_word & mask)) else $error("write-back data");
	a_apl_test_flag: assert property (apl_done |->
		test_control_flag_out == (mem_wb_out.data == 16'h0) && $stable(carry_flag_out)
		&& $stable(result_saturated_flag_out)) else $error("test flag");
	a_apl_words: assert property (apl_done |->
		pc_advance_out == (rq_reg.long_imm_given ? 2'h2 : 2'h1)) else $error("word count");
	a_apl_address: assert property (apl_done |-> mem_wb_out.indirect == rq_reg.opcode[7] &&
		(rq_reg.opcode[7] || mem_wb_out.offset == rq_reg.opcode[6:0])) else $error("address");
	c_and_with_buffer: cover property (and_with_buffer_go);
	c_add_product_to_sum_register: cover property (done_out && rq_reg.op == LPA_OP_ADD_PRODUCT_TO_SUM_REGISTER);
	c_apl_zero: cover property (apl_done && mem_wb_out.data == 16'h0);
endmodule
bind lpa_datapath lpa_datapath_chk u_lpa_datapath_chk (.*);

//--- sim/lpa_datapath_test.sv
// lpa_datapath_test: random and corner ops, self-checking
// assumes: package, design and checker compiled first
`timescale 1ns/10ps
module lpa_datapath_test
	import lpa_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, ld = 1'b0, sat = 1'b0, sign_extension_mode = 1'b0;
	logic [31:0] a = '0, b = '0, p = '0, sum, h, pr;
	logic [15:0] mk = '0, w;
	logic [1:0] pm = '0, pc, pmo;
	logic busy, done, cy, ov, tc, cm, om, tm, v;
	logic [32:0] s;
	lpa_req_t rq = '0, r;
	lpa_wb_t wb;
	int seed = 81515, num_errors = 0, checks_done = 0, k;
	always #10 clk = ~clk;
	// one load strobe feeds every register load, so each op starts from known values
	lpa_datapath u_lpa_datapath (.clk_in(clk), .rst_b_in(rst_b), .start_in(go), .req_in(rq),
		.product_shift_mode_load_in(ld), .product_shift_mode_in(pm), .saturation_enable_in(sat),
		.sign_extension_mode_in(sign_extension_mode), .sum_buffer_load_in(b), .sum_buffer_we_in(ld),
		.product_load_in(p), .product_we_in(ld), .dynamic_bit_mask_in(mk),
		.dynamic_bit_mask_we_in(ld), .sum_load_in(a), .sum_we_in(ld), .busy_out(busy),
		.done_out(done), .main_sum_register_out(sum), .sum_buffer_register_out(),
		.product_register_out(pr), .dynamic_bit_mask_register_out(),
		.product_shift_mode_out(pmo),
		.carry_flag_out(cy), .result_saturated_flag_out(ov), .test_control_flag_out(tc),
		.pc_advance_out(pc), .mem_wb_out(wb));
	task automatic chk(logic [31:0] g, logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// cycles from the taking edge to done, per memory kind and repeat count
	function automatic int exp_cyc(lpa_req_t q);
		int n, c;
		n = (q.repeat_n < 8'h2) ? 1 : int'(q.repeat_n);
		c = n;
		if (q.op == LPA_OP_APL && q.operand_mem == LPA_MEM_SINGLE) c = (n < 2) ? 1 : 2 * n - 2;
		if (q.op == LPA_OP_APL && q.operand_mem == LPA_MEM_SHARED) c = (n < 2) ? 3 : 2 * n + 1;
		if (q.op == LPA_OP_APL && q.operand_mem == LPA_MEM_EXT)
			c = ((n < 2) ? 2 + 2 * q.wait_d : 4 * n - 2 + 2 * n * q.wait_d) + 3 * q.code_external;
		return c + (q.code_external ? int'(q.wait_p) : 0);
	endfunction
	initial begin
		{cm, om, tm} = 3'h0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			r = lpa_req_t'(70'({$random(seed), $random(seed), $random(seed)}));
			r.op = lpa_op_t'(i % 3);
			// repeated add-product still adds only once, n only sets the cycles; kept single here
			r.repeat_n &= (r.op == LPA_OP_ADD_PRODUCT_TO_SUM_REGISTER) ? 8'h1 : 8'h7;
			if (r.operand_mem == LPA_MEM_SHARED) r.code_external = 1'b0;
			// corner: zero result through the mask, then through the immediate
			if (i < 9) begin
				r.long_imm_given = i[0];
				r.long_imm = ~r.mem_word;
			end
			@(posedge clk);
			a <= $random(seed);
			b <= $random(seed);
			p <= $random(seed);
			mk <= (i < 9) ? ~r.mem_word : 16'($random(seed));
			pm <= i[1:0];
			sat <= i[2];
			sign_extension_mode <= i[3];
			ld <= 1'b1;
			@(posedge clk);
			ld <= 1'b0;
			go <= 1'b1;
			rq <= r;
			@(posedge clk);
			// start still high while busy: must be refused
			@(posedge clk);
			go <= 1'b0;
			k = 1;
			@(negedge clk);
			while (done !== 1'b1 && k < 400) begin
				@(negedge clk);
				k++;
			end
			if (k == 400) begin
				num_errors++;
				$display("[FAIL] %0t no done within bound", $time);
				end_sim();
			end
			case (pm)
				2'h1: h = p << 1;
				2'h2: h = p << 4;
				2'h3: h = $signed(p) >>> 6;
				default: h = p;
			endcase
			s = {1'b0, a} + {1'b0, h};
			v = a[31] == h[31] && s[31] != a[31];
			if (v && sat) s[31:0] = a[31] ? 32'h80000000 : 32'h7fffffff;
			w = r.mem_word & (r.long_imm_given ? r.long_imm : mk);
			if (r.op == LPA_OP_ADD_PRODUCT_TO_SUM_REGISTER) {cm, om} = {s[32], om | v};
			if (r.op == LPA_OP_APL) tm = (w == 16'h0);
			chk(sum, r.op == LPA_OP_AND_WITH_BUFFER ? a & b : r.op == LPA_OP_ADD_PRODUCT_TO_SUM_REGISTER ? s[31:0] : a);
			chk(32'({cy, ov, tc}), 32'({cm, om, tm}));
			chk(32'(pc), (r.op == LPA_OP_APL && r.long_imm_given) ? 32'h2 : 32'h1);
			chk(32'(k), 32'(exp_cyc(r)));
			if (r.op == LPA_OP_APL) chk(32'({wb.we, wb.data}), 32'({1'b1, w}));
			chk(pr, p);
			chk(32'({busy, pmo}), 32'({1'b0, pm}));
			$display("op %0d done", i);
		end
		end_sim();
	end
endmodule
